// ===== rtl/lfm_pkg.sv
/*
 * Constants, types and lookup functions for the LED fault monitor.
 * Assumes a 125 MHz system clock; all times are converted to cycles here.
 */
package lfm_pkg;

    localparam int CLK_KHZ      = 125000;
    localparam int EN_LOW_MS    = 50;
    localparam int PULSE_MS     = 500;
    localparam int EN_LOW_CYC   = EN_LOW_MS * CLK_KHZ;
    localparam int PULSE_CYC    = PULSE_MS * CLK_KHZ;
    localparam int TMR_W        = 26;
    localparam int OC_PERIODS   = 16;

    localparam logic [7:0] SHORT_CODE   = 8'h06;
    localparam logic [7:0] DERATE_NUM   = 8'h03;
    localparam int         DERATE_SHIFT = 2;
    localparam logic [7:0] STAT_RESET   = 8'h00;

    // Global status one
    localparam int GS1_UV     = 6;
    localparam int GS1_DUTY   = 5;
    localparam int GS1_DERATE = 4;
    // Global status two
    localparam int GS2_WARN   = 6;
    localparam int GS2_SHUT   = 5;
    localparam int GS2_FRAME  = 4;
    // Channel status
    localparam int CH_OPEN    = 3;
    localparam int CH_SHORT   = 2;
    localparam int CH_SINGLE  = 1;
    localparam int CH_OC      = 0;

    typedef enum logic [1:0] {
        LFM_RD_GS1 = 2'h0,
        LFM_RD_GS2 = 2'h1,
        LFM_RD_CH1 = 2'h2,
        LFM_RD_CH2 = 2'h3
    } lfm_rd_sel_t;

    typedef struct packed {
        logic       en_pin;      // Channel enable pin, asynchronous
        logic [7:0] led_code;    // LED string voltage, 80 V full scale
        logic       open_hit;    // Open string comparator
        logic       oc_over;     // Buck switch above overcurrent level
        logic       buck_tick;   // One pulse per buck period
        logic [7:0] duty_prog;   // Programmed dimming duty
    } lfm_chan_in_t;

    // Boost undervoltage level in volts per booster range
    function automatic logic [7:0] lfm_uv_level(input logic [3:0] rng);
        case (rng)
            4'h0, 4'h1, 4'h2: lfm_uv_level = 8'h0D;
            4'h3: lfm_uv_level = 8'h0F;
            4'h4: lfm_uv_level = 8'h12;
            4'h5: lfm_uv_level = 8'h14;
            4'h6: lfm_uv_level = 8'h17;
            4'h7: lfm_uv_level = 8'h19;
            4'h8: lfm_uv_level = 8'h1C;
            4'h9: lfm_uv_level = 8'h1E;
            4'hA: lfm_uv_level = 8'h21;
            4'hB: lfm_uv_level = 8'h23;
            4'hC: lfm_uv_level = 8'h26;
            4'hD: lfm_uv_level = 8'h28;
            4'hE: lfm_uv_level = 8'h2D;
            default: lfm_uv_level = 8'h37;
        endcase
    endfunction : lfm_uv_level

    // Flag update where a new event beats a clear in the same cycle
    function automatic logic lfm_flag(input logic cur, input logic set,
                                      input logic clr);
        lfm_flag = set | (cur & ~clr);
    endfunction : lfm_flag

endpackage : lfm_pkg

// ===== rtl/lfm_sync.sv
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clock; output is a clean level.
 */
`timescale 1ns/100ps
module lfm_sync (
    input  wire logic clock,    // System clock
    input  wire logic rst_n,    // Synchronised reset, active low
    input  wire logic d_in,     // Asynchronous input
    output logic      q_out     // Filtered, synchronous level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // A change counts only once the second and third stage agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            q_out <= 1'b0;
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_out <= s3_q;
            end
        end
    end
endmodule : lfm_sync

// ===== rtl/lfm_chan.sv
/*
 * Per-channel timing: enable-low clear timer, overcurrent period counter
 * and the one-shot window for pulsed diagnostic mode.
 * Assumes buck_tick is one cycle wide and synchronous to clock.
 */
`timescale 1ns/100ps
module lfm_chan #(
    parameter int EN_LOW_CYC = lfm_pkg::EN_LOW_CYC,
    parameter int PULSE_CYC  = lfm_pkg::PULSE_CYC
) (
    input  wire logic clock,      // System clock
    input  wire logic rst_n,      // Synchronised reset, active low
    input  wire logic en_pin,     // Enable pin, asynchronous
    input  wire logic buck_tick,  // Buck period pulse
    input  wire logic oc_over,    // Switch current above level
    output logic      en_level,   // Synchronised enable
    output logic      low_fire,   // Enable low beyond limit, pulse
    output logic      oc_trip,    // Overcurrent persisted, pulse
    output logic      pulse_win   // Pulsed-mode high window
);
    localparam int TMR_BITS = lfm_pkg::TMR_W;
    localparam logic [TMR_BITS-1:0] LOW_END   = TMR_BITS'(EN_LOW_CYC);
    localparam logic [TMR_BITS-1:0] PULSE_LEN = TMR_BITS'(PULSE_CYC);
    localparam logic [4:0] OC_LAST = 5'(lfm_pkg::OC_PERIODS - 1);

    logic [lfm_pkg::TMR_W-1:0] low_q;
    logic [lfm_pkg::TMR_W-1:0] pul_q;
    logic [4:0]                oc_q;
    logic                      en_prev_q;
    wire                       en_rise;

    lfm_sync u_en_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d_in  (en_pin),
        .q_out (en_level)
    );

    assign en_rise   = en_level & ~en_prev_q;
    // Timer restarts on any high level and fires once
    assign low_fire  = ~en_level & (low_q == LOW_END - 1'b1);
    assign oc_trip   = buck_tick & oc_over & (oc_q == OC_LAST);
    assign pulse_win = en_level & (pul_q != '0);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_q     <= '0;
            oc_q      <= 5'h00;
            pul_q     <= '0;
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= en_level;
            if (en_level) begin
                low_q <= '0;
            end else if (low_q != LOW_END) begin
                low_q <= low_q + 1'b1;
            end
            if (buck_tick) begin
                oc_q <= oc_over ? ((oc_q == OC_LAST) ? oc_q : oc_q + 5'h01)
                                : 5'h00;
            end
            if (en_rise) begin
                pul_q <= PULSE_LEN;
            end else if (pul_q != '0) begin
                pul_q <= pul_q - 1'b1;
            end
        end
    end
endmodule : lfm_chan

// ===== rtl/lfm_monitor.sv
/*
 * Fault detection and reporting for a two-channel LED driver with boost.
 * Latches status flags, gates booster and buck enables on thermal state,
 * derates duty and drives one diagnostic pin per channel.
 * Assumes comparator and ADC results arrive synchronous to clock, except
 * the channel enable pins which are synchronised here. Status reads are
 * strobes from the serial front end in the same clock domain.
 */
`timescale 1ns/100ps

// Contract
// - Thermal warning cuts duty to three quarters
// - Shutdown disables booster and both outputs
// - Shutdown flag latched until status two read
// - Re-enable uses live signals, both deasserted
// - Frame length not multiple of sixteen flagged
// - Undervoltage flag, both pins low, cleared
// - Open string flag, pin low, cleared
// - Undervoltage level follows booster range table
// - String short below code 06 hex
// - Single short below programmable threshold
// - Threshold default from storage, writable override
// - Single short only sets status
// - Overcurrent sixteen periods flags, channel off
// - Overcurrent flag cleared by read or enable
// - Mode bit selects static or pulsed pin
// - Static mode: pin high while active, clean
// - Pulsed mode: single 500 ms high pulse
// - Pin low while any channel error persists
// - Status bit placement in three registers
// - Duty limit flag, cleared by read only
// - Derate flag set when derating active
module lfm_monitor #(
    parameter int EN_LOW_CYC = lfm_pkg::EN_LOW_CYC,
    parameter int PULSE_CYC  = lfm_pkg::PULSE_CYC
) (
    input  wire logic                 clock,           // 125 MHz clock
    input  wire logic                 rstn,            // Async reset, low
    input  wire lfm_pkg::lfm_chan_in_t ch1_in,         // Channel 1 inputs
    input  wire lfm_pkg::lfm_chan_in_t ch2_in,         // Channel 2 inputs
    input  wire logic                 thermal_warning,  // Live warning
    input  wire logic                 thermal_shutdown, // Live shutdown
    input  wire logic                 duty_limit_hit,   // Booster at max
    input  wire logic                 derate_disable,   // Derating off
    input  wire logic [3:0]           boost_range,      // Booster range
    input  wire logic [7:0]           boost_volt,       // Boost volts
    input  wire logic                 diag_pulsed_mode, // Mode bit
    input  wire logic [7:0]           thr1_nvm,         // Stored default
    input  wire logic [7:0]           thr2_nvm,         // Stored default
    input  wire logic                 thr_wr,           // Override write
    input  wire logic                 thr_wr_ch,        // 0: ch1, 1: ch2
    input  wire logic [7:0]           thr_wr_data,      // Override value
    input  wire logic                 frame_done,       // Frame ended
    input  wire logic [7:0]           frame_bits,       // Bits in frame
    input  wire logic                 rd_stb,           // Status read
    input  wire lfm_pkg::lfm_rd_sel_t rd_sel,           // Which register
    output logic [7:0]                rd_data,          // Read result
    output logic                      booster_en,       // Booster on
    output logic [1:0]                string_drive_en,  // Buck channels on
    output logic [7:0]                duty1_out,        // Applied duty 1
    output logic [7:0]                duty2_out,        // Applied duty 2
    output logic [1:0]                fault_report_pin  // Diagnostic pins
);
    logic rst_s1_q;
    logic rst_n;

    // Reset asserts at once and releases through two flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    wire [1:0] en_level;
    wire [1:0] low_fire;
    wire [1:0] oc_trip;
    wire [1:0] pulse_win;

    lfm_chan #(
        .EN_LOW_CYC (EN_LOW_CYC),
        .PULSE_CYC  (PULSE_CYC)
    ) u_ch1 (
        .clock     (clock),
        .rst_n     (rst_n),
        .en_pin    (ch1_in.en_pin),
        .buck_tick (ch1_in.buck_tick),
        .oc_over   (ch1_in.oc_over),
        .en_level  (en_level[0]),
        .low_fire  (low_fire[0]),
        .oc_trip   (oc_trip[0]),
        .pulse_win (pulse_win[0])
    );

    lfm_chan #(
        .EN_LOW_CYC (EN_LOW_CYC),
        .PULSE_CYC  (PULSE_CYC)
    ) u_ch2 (
        .clock     (clock),
        .rst_n     (rst_n),
        .en_pin    (ch2_in.en_pin),
        .buck_tick (ch2_in.buck_tick),
        .oc_over   (ch2_in.oc_over),
        .en_level  (en_level[1]),
        .low_fire  (low_fire[1]),
        .oc_trip   (oc_trip[1]),
        .pulse_win (pulse_win[1])
    );

    // Single short thresholds: stored default until a write overrides
    logic [7:0] thr1_q;
    logic [7:0] thr2_q;
    logic [1:0] thr_ovr_q;
    wire  [7:0] thr1_eff;
    wire  [7:0] thr2_eff;

    assign thr1_eff = thr_ovr_q[0] ? thr1_q : thr1_nvm;
    assign thr2_eff = thr_ovr_q[1] ? thr2_q : thr2_nvm;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            thr1_q    <= 8'h00;
            thr2_q    <= 8'h00;
            thr_ovr_q <= 2'h0;
        end else if (thr_wr) begin
            if (thr_wr_ch) begin
                thr2_q       <= thr_wr_data;
                thr_ovr_q[1] <= 1'b1;
            end else begin
                thr1_q       <= thr_wr_data;
                thr_ovr_q[0] <= 1'b1;
            end
        end
    end

    // Thermal hold ends only when both live signals are gone
    logic therm_hold_q;
    wire  therm_hold_d;

    assign therm_hold_d = thermal_shutdown |
                          (therm_hold_q & thermal_warning);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            therm_hold_q <= 1'b0;
        end else begin
            therm_hold_q <= therm_hold_d;
        end
    end

    // Detection terms
    wire       uv_hit;
    wire [1:0] open_hit;
    wire [1:0] short_hit;
    wire [1:0] single_hit;
    wire       derate_on;
    wire       frame_err;

    assign uv_hit = boost_volt < lfm_pkg::lfm_uv_level(boost_range);
    assign open_hit   = {ch2_in.open_hit, ch1_in.open_hit} & en_level;
    assign short_hit  = {ch2_in.led_code < lfm_pkg::SHORT_CODE,
                         ch1_in.led_code < lfm_pkg::SHORT_CODE}
                        & en_level;
    assign single_hit = {ch2_in.led_code < thr2_eff,
                         ch1_in.led_code < thr1_eff} & en_level;
    assign derate_on  = thermal_warning & ~derate_disable;
    assign frame_err  = frame_done & (frame_bits[3:0] != 4'h0);

    // Clear sources
    wire       rd_gs1;
    wire       rd_gs2;
    wire [1:0] rd_ch;
    wire       uv_clr;

    assign rd_gs1 = rd_stb & (rd_sel == lfm_pkg::LFM_RD_GS1);
    assign rd_gs2 = rd_stb & (rd_sel == lfm_pkg::LFM_RD_GS2);
    assign rd_ch  = {rd_stb & (rd_sel == lfm_pkg::LFM_RD_CH2),
                     rd_stb & (rd_sel == lfm_pkg::LFM_RD_CH1)};
    assign uv_clr = rd_gs1 | (|low_fire);

    // Latched flags
    logic       uv_q;
    logic       duty_q;
    logic       derate_q;
    logic       shut_q;
    logic       frame_q;
    logic [1:0] open_q;
    logic [1:0] short_q;
    logic [1:0] single_q;
    logic [1:0] oc_q;
    logic [1:0] ch_clr;

    assign ch_clr = rd_ch | low_fire;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            uv_q     <= 1'b0;
            duty_q   <= 1'b0;
            derate_q <= 1'b0;
            shut_q   <= 1'b0;
            frame_q  <= 1'b0;
            open_q   <= 2'h0;
            short_q  <= 2'h0;
            single_q <= 2'h0;
            oc_q     <= 2'h0;
        end else begin
            uv_q     <= lfm_pkg::lfm_flag(uv_q, uv_hit, uv_clr);
            duty_q   <= lfm_pkg::lfm_flag(duty_q, duty_limit_hit,
                                          rd_gs1);
            derate_q <= lfm_pkg::lfm_flag(derate_q, derate_on,
                                          rd_gs1);
            shut_q   <= lfm_pkg::lfm_flag(shut_q, thermal_shutdown,
                                          rd_gs2);
            frame_q  <= lfm_pkg::lfm_flag(frame_q, frame_err,
                                          rd_gs2);
            for (int i = 0; i < 2; i++) begin
                open_q[i]   <= lfm_pkg::lfm_flag(open_q[i], open_hit[i],
                                                 ch_clr[i]);
                short_q[i]  <= lfm_pkg::lfm_flag(short_q[i], short_hit[i],
                                                 ch_clr[i]);
                single_q[i] <= lfm_pkg::lfm_flag(single_q[i],
                                                 single_hit[i],
                                                 ch_clr[i]);
                oc_q[i]     <= lfm_pkg::lfm_flag(oc_q[i], oc_trip[i],
                                                 ch_clr[i]);
            end
        end
    end

    // Status layout; warning bit shows the live signal
    wire [7:0] gs1_val;
    wire [7:0] gs2_val;
    wire [7:0] ch1_val;
    wire [7:0] ch2_val;
    wire [7:0] rd_mux;

    assign gs1_val = {1'b0, uv_q, duty_q, derate_q, 4'h0};
    assign gs2_val = {1'b0, thermal_warning, shut_q, frame_q, 4'h0};
    assign ch1_val = {4'h0, open_q[0], short_q[0], single_q[0],
                      oc_q[0]};
    assign ch2_val = {4'h0, open_q[1], short_q[1], single_q[1],
                      oc_q[1]};
    assign rd_mux  = (rd_sel == lfm_pkg::LFM_RD_GS1) ? gs1_val :
                     (rd_sel == lfm_pkg::LFM_RD_GS2) ? gs2_val :
                     (rd_sel == lfm_pkg::LFM_RD_CH1) ? ch1_val : ch2_val;

    // Outputs
    wire [1:0]  drive_d;
    wire [1:0]  chan_err;
    wire [1:0]  pin_d;
    wire [15:0] der1;
    wire [15:0] der2;

    // Live hold term so both strings drop on the same edge as the booster
    assign drive_d  = en_level & ~oc_q & {2{~therm_hold_d}};
    // Single short is deliberately absent from the pin error
    assign chan_err = open_q | short_q | oc_q |
                      {2{uv_q | therm_hold_q}};
    assign pin_d    = diag_pulsed_mode ? (pulse_win & ~chan_err)
                                       : (drive_d & ~chan_err);
    assign der1 = 16'(ch1_in.duty_prog * lfm_pkg::DERATE_NUM)
                  >> lfm_pkg::DERATE_SHIFT;
    assign der2 = 16'(ch2_in.duty_prog * lfm_pkg::DERATE_NUM)
                  >> lfm_pkg::DERATE_SHIFT;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data          <= lfm_pkg::STAT_RESET;
            booster_en       <= 1'b0;
            string_drive_en  <= 2'h0;
            duty1_out        <= 8'h00;
            duty2_out        <= 8'h00;
            fault_report_pin <= 2'h0;
        end else begin
            if (rd_stb) begin
                rd_data <= rd_mux;
            end
            booster_en       <= ~therm_hold_d;
            string_drive_en  <= drive_d;
            duty1_out        <= derate_on ? der1[7:0]
                                          : ch1_in.duty_prog;
            duty2_out        <= derate_on ? der2[7:0]
                                          : ch2_in.duty_prog;
            fault_report_pin <= pin_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    shutdown_cuts_power_a: assert property (
        thermal_shutdown |=> !booster_en && string_drive_en == 2'h0)
        else $error("Outputs still on after shutdown");

    shut_flag_holds_a: assert property (
        shut_q && !rd_gs2 |=> shut_q)
        else $error("Shutdown flag lost without read");

    resume_after_live_a: assert property (
        therm_hold_q && !thermal_shutdown && !thermal_warning
        |=> booster_en)
        else $error("Booster not resumed after thermal clear");

    frame_err_set_a: assert property (
        frame_done && frame_bits[3:0] != 4'h0 |=> gs2_val[5:4] ==
        {shut_q, 1'b1})
        else $error("Frame error not flagged");

    uv_pins_low_a: assert property (
        uv_q |=> fault_report_pin == 2'h0)
        else $error("Pins not low on undervoltage");

    derate_duty_a: assert property (
        derate_on |=>
        duty1_out == 8'((16'($past(ch1_in.duty_prog)) * 16'h0003) >> 2))
        else $error("Duty not derated");

    oc_drive_off_a: assert property (
        oc_q[0] |=> !string_drive_en[0])
        else $error("Channel still on with overcurrent");

    set_beats_read_a: assert property (
        duty_limit_hit && rd_gs1 |=> duty_q)
        else $error("Duty limit event lost on read");

    single_no_pin_a: assert property (
        single_q[0] && !diag_pulsed_mode && drive_d[0] && !chan_err[0]
        |=> fault_report_pin[0])
        else $error("Single short affected the pin");

    enable_low_clear_a: assert property (
        low_fire[0] && !oc_trip[0] |=> !oc_q[0] && !open_q[0])
        else $error("Enable low did not clear flags");

    shutdown_seen_c:  cover property (thermal_shutdown ##1 shut_q);
    oc_trip_c:        cover property (oc_trip[0]);
    pulsed_pin_c:     cover property (diag_pulsed_mode &&
                                      fault_report_pin[1]);
    low_fire_c:       cover property (low_fire[1] ##1 !uv_q);

endmodule : lfm_monitor

// ===== testbench/lfm_mcu_model.sv
/*
 * Companion controller model: drives both channel enable pins.
 * Assumes the bench sets the wanted levels on en_req between edges.
 */
`timescale 1ns/100ps
module lfm_mcu_model (
    input  wire logic       clock,   // System clock
    input  wire logic [1:0] en_req,  // Wanted enable levels
    output logic [1:0]      en_pin   // Enable pins to the device
);
    // Pins move just after a rising edge, as a port register would
    always @(posedge clock) begin
        en_pin <= en_req;
    end
endmodule : lfm_mcu_model

// ===== testbench/lfm_monitor_tb.sv
/*
 * Self-checking bench for lfm_monitor with shortened timers.
 * Assumes lfm_mcu_model drives the enable pins; inputs move at negedge.
 */
`timescale 1ns/100ps
module lfm_monitor_tb;
    localparam int LOW = 20;
    localparam int PUL = 50;
    logic       clock = 0, rstn = 0, rd_stb = 0, thr_wr = 0;
    logic       warn = 0, shut = 0, dlim = 0, fdone = 0, pmode = 0;
    logic [7:0] fbits = 0, bvolt = 8'hFF, rd_data, d1, d2;
    logic [3:0] rng = 0;
    logic [1:0] rsel = 0, en_req = 0, en_pin, drv, pin;
    logic       booster_en;
    lfm_pkg::lfm_chan_in_t c1, c2;
    int n_errors = 0, num_checks = 0, cnt = 0, r, p;
    int m[4] = '{0, 0, 0, 0};
    int uv[16] = '{13, 13, 13, 15, 18, 20, 23, 25,
                   28, 30, 33, 35, 38, 40, 45, 55};

    lfm_mcu_model i_mcu (.clock(clock), .en_req(en_req), .en_pin(en_pin));
    lfm_monitor #(.EN_LOW_CYC(LOW), .PULSE_CYC(PUL)) i_dut (
        .clock(clock), .rstn(rstn),
        .ch1_in({en_pin[0], c1[18:0]}), .ch2_in({en_pin[1], c2[18:0]}),
        .thermal_warning(warn), .thermal_shutdown(shut),
        .duty_limit_hit(dlim), .derate_disable(1'b0),
        .boost_range(rng), .boost_volt(bvolt),
        .diag_pulsed_mode(pmode), .thr1_nvm(8'h10), .thr2_nvm(8'h10),
        .thr_wr(thr_wr), .thr_wr_ch(1'b0), .thr_wr_data(8'hC0),
        .frame_done(fdone), .frame_bits(fbits), .rd_stb(rd_stb),
        .rd_sel(lfm_pkg::lfm_rd_sel_t'(rsel)), .rd_data(rd_data),
        .booster_en(booster_en), .string_drive_en(drv),
        .duty1_out(d1), .duty2_out(d2), .fault_report_pin(pin));

    initial begin
        forever #4 clock = ~clock;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Run is a few hundred cycles; a hang stops well past that
    always @(posedge clock) begin
        cnt++;
        if (cnt == 3000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : chk

    // Model clears on read; the warning bit follows the live input
    task automatic rd(input int s);
        rsel = s[1:0];
        rd_stb = 1;
        cyc(1);
        rd_stb = 0;
        cyc(1);
        chk("rd_data", m[s][7:0], rd_data);
        m[s] = (s == 1) ? (m[s] & 32'h40) : 0;
    endtask : rd

    task automatic tick(input logic oc);
        c2.oc_over = oc;
        c2.buck_tick = 1;
        cyc(1);
        c2.buck_tick = 0;
        cyc(1);
    endtask : tick

    initial begin
        void'($urandom(77));
        c1 = '0;
        c1.led_code = 8'hFF;
        c2 = c1;
        cyc(2);
        rstn = 1;
        cyc(6);
        for (int i = 0; i < 4; i++) rd(i);
        $display("done reset");
        fbits = 8'd32;
        fdone = 1;
        cyc(1);
        fbits = 8'd17;
        cyc(1);
        fdone = 0;
        m[1] = 32'h10;
        rd(1);
        rd(1);
        $display("done frame");
        c1.duty_prog = 8'($urandom);
        p = c1.duty_prog;
        c2.duty_prog = 8'($urandom);
        en_req = 2'h3;
        cyc(8);
        chk("on", 8'h7, {5'h0, booster_en, drv});
        chk("pin", 8'h3, {6'h0, pin});
        warn = 1;
        cyc(3);
        chk("duty1", 8'(p * 3 / 4), d1);
        chk("duty2", 8'(c2.duty_prog * 3 / 4), d2);
        shut = 1;
        cyc(2);
        chk("on", 8'h0, {5'h0, booster_en, drv});
        chk("pin", 8'h0, {6'h0, pin});
        shut = 0;
        cyc(3);
        chk("on", 8'h0, {5'h0, booster_en, drv});
        warn = 0;
        dlim = 1;
        cyc(1);
        dlim = 0;
        cyc(2);
        chk("on", 8'h7, {5'h0, booster_en, drv});
        chk("duty1", p[7:0], d1);
        m[0] = 32'h30;
        m[1] = 32'h20;
        rd(1);
        rd(0);
        $display("done thermal");
        c1.open_hit = 1;
        cyc(2);
        c1.open_hit = 0;
        cyc(2);
        chk("pin", 8'h2, {6'h0, pin});
        en_req = 2'h2;
        cyc(LOW + 10);
        en_req = 2'h3;
        cyc(8);
        chk("pin", 8'h3, {6'h0, pin});
        rd(2);
        $display("done open");
        for (int i = 0; i < 32; i++) begin
            tick(i != 15);
            if (i == 30) chk("drv", 8'hF, {4'h0, drv, pin});
        end
        c2.oc_over = 0;
        cyc(1);
        chk("drv", 8'h5, {4'h0, drv, pin});
        m[3] = 1;
        rd(3);
        cyc(2);
        chk("drv", 8'hF, {4'h0, drv, pin});
        $display("done overcurrent");
        thr_wr = 1;
        cyc(1);
        thr_wr = 0;
        c1.led_code = 8'h80;
        cyc(3);
        c1.led_code = 8'hFF;
        cyc(1);
        chk("pin", 8'h3, {6'h0, pin});
        m[2] = 2;
        rd(2);
        $display("done single short");
        r = $urandom_range(15);
        rng = r[3:0];
        bvolt = 8'(uv[r] - 1);
        cyc(3);
        bvolt = 8'hFF;
        cyc(1);
        chk("pin", 8'h0, {6'h0, pin});
        m[0] = 32'h40;
        dlim = 1;
        rd(0);
        dlim = 0;
        cyc(2);
        chk("pin", 8'h3, {6'h0, pin});
        m[0] = 32'h20;
        rd(0);
        $display("done undervoltage");
        pmode = 1;
        en_req = 2'h0;
        cyc(LOW + 10);
        en_req = 2'h3;
        cyc(8);
        chk("pin", 8'h3, {6'h0, pin});
        cyc(PUL);
        chk("pin", 8'h0, {6'h0, pin});
        $display("done pulsed");
        final_report();
    end
endmodule : lfm_monitor_tb
